// ==== verif/rtc_osc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_model (
    input wire logic core_clk, // Core clock
    input wire logic run, // Oscillator enabled
    output logic osc_clk_in = 1'h0 // Slow clock, low when stopped
);
    logic [2:0] div = 3'h0;
    always @(posedge core_clk) begin
        div <= run ? div + 3'h1 : 3'h0;
        osc_clk_in <= #1 run & div[2];
    end
endmodule : rtc_osc_model
`default_nettype wire

// ==== verif/rtc_time_date_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_time_date_chk (
    input wire logic core_clk, // Clock
    input wire logic srst, // Reset
    input wire logic [7:0] reg_addr, // Offset
    input wire logic reg_wr, // Write
    input wire logic [7:0] reg_wdata, // Wdata
    input wire logic [7:0] reg_rdata, // Rdata
    input wire logic sec_carry, // Tick
    input wire logic [4:0] month_bcd, // Month
    input wire logic leap_year, // Leap
    input wire logic osc_enable, // Osc on
    input wire logic osc_clk_in, // Osc
    input wire logic primary_power_lost, // Loss
    input wire logic day_carry, // Carry
    input wire logic osc_running_flag, // Running
    input wire logic power_loss_flag, // Lost
    input wire logic backup_supply_enable, // Backup
    input wire logic timestamp_clear // Clear
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    AST_RD_TOP: assert property (reg_rdata[7] == 1'h0) else $error("rdata bit 7 set");
    AST_RD_DAY: assert property ($past(reg_addr) == 8'h04 |-> reg_rdata[7:6] == 2'h0)
        else $error("day top bits set");
    AST_RD_UNMAP: assert property ($past(reg_addr) == 8'h00 || $past(reg_addr) > 8'h04 |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_FLAGS: assert property ($past(reg_addr) == 8'h03 |->
        reg_rdata[5:3] == $past({osc_running_flag, power_loss_flag, backup_supply_enable}))
        else $error("weekday flags differ from pins");
    AST_MIN_WR: assert property ((reg_wr && reg_addr == 8'h01 && !sec_carry) ##1
        (reg_addr == 8'h01 && !reg_wr && !sec_carry) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h7f))
        else $error("minutes write not read back");
    AST_BACKUP: assert property (reg_wr && reg_addr == 8'h03 |=> backup_supply_enable == $past(reg_wdata[3]))
        else $error("backup enable not written");
    AST_PWR_CLR: assert property (reg_wr && reg_addr == 8'h03 && power_loss_flag && !primary_power_lost
        |=> timestamp_clear && !power_loss_flag) else $error("power flag not cleared");
    AST_PWR_SET: assert property ($rose(primary_power_lost) |-> ##[2:6] power_loss_flag)
        else $error("power flag not set");
    AST_TS_CAUSE: assert property (timestamp_clear |-> $past(reg_wr) && $past(reg_addr) == 8'h03)
        else $error("stray stamp clear");
    AST_DAY_CARRY: assert property (day_carry |-> $past(sec_carry) ##1 !day_carry)
        else $error("bad day carry");
    AST_OSC_OFF: assert property (!osc_enable ##1 !osc_enable |-> !osc_running_flag)
        else $error("osc flag while disabled");
endmodule : rtc_time_date_chk
bind rtc_time_date rtc_time_date_chk u_chk (
    .core_clk(core_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .sec_carry(sec_carry),
    .month_bcd(month_bcd),
    .leap_year(leap_year),
    .osc_enable(osc_enable),
    .osc_clk_in(osc_clk_in),
    .primary_power_lost(primary_power_lost),
    .day_carry(day_carry),
    .osc_running_flag(osc_running_flag),
    .power_loss_flag(power_loss_flag),
    .backup_supply_enable(backup_supply_enable),
    .timestamp_clear(timestamp_clear)
);
`default_nettype wire

// ==== verif/rtc_time_date_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_time_date_tb_top;
    logic core_clk = 1'h0;
    logic srst = 1'h1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, exp, d, got;
    logic reg_wr = 1'h0, sec_carry = 1'h0, leap_year = 1'h0, osc_enable = 1'h0;
    logic primary_power_lost = 1'h0, rd_req = 1'h0, rd_seen = 1'h0;
    logic pin_req = 1'h0, pin_seen = 1'h0, osc_stall = 1'h0;
    logic [4:0] month_bcd = 5'h02;
    logic osc_clk_in, day_carry, osc_running_flag, power_loss_flag, backup_supply_enable, timestamp_clear;
    logic [7:0] hin[3] = '{8'h71, 8'h51, 8'h52};
    logic [7:0] hout[3] = '{8'h52, 8'h72, 8'h41};
    logic [7:0] exp_q[$];
    string nm_q[$];
    string nm;
    int err_count = 0, cmp_count = 0, cyc = 0, seed = 32'h2487_a8fd;
    int carry_n = 0, clr_n = 0;
    rtc_time_date #(.OSC_LOSS_CYCLES(50)) DUT (
        .core_clk(core_clk),
        .srst(srst),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .sec_carry(sec_carry),
        .month_bcd(month_bcd),
        .leap_year(leap_year),
        .osc_enable(osc_enable),
        .osc_clk_in(osc_clk_in),
        .primary_power_lost(primary_power_lost),
        .day_carry(day_carry),
        .osc_running_flag(osc_running_flag),
        .power_loss_flag(power_loss_flag),
        .backup_supply_enable(backup_supply_enable),
        .timestamp_clear(timestamp_clear)
    );
    // Stall stops the slow clock while the enable stays high
    rtc_osc_model osc (.core_clk(core_clk), .run(osc_enable && !osc_stall), .osc_clk_in(osc_clk_in));
    initial forever #10 core_clk = ~core_clk;
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (day_carry === 1'h1) carry_n++;
        if (timestamp_clear === 1'h1) clr_n++;
        if (rd_seen || pin_seen) begin
            got = rd_seen ? reg_rdata : {5'h00, osc_running_flag, power_loss_flag, backup_supply_enable};
            exp = exp_q.pop_front();
            nm = nm_q.pop_front();
            cmp_count++;
            if (got !== exp) begin
                err_count++;
                $display("BAD %s exp %h got %h", nm, exp, got);
            end
        end
        rd_seen <= rd_req;
        pin_seen <= pin_req;
        if (cyc == 5000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge core_clk) #1;
        reg_addr = a;
        rd_req = 1'h1;
        exp_q.push_back(e);
        nm_q.push_back(n);
        @(posedge core_clk) #1;
        rd_req = 1'h0;
    endtask : rd
    task automatic pins(input logic [7:0] e, input string n);
        @(posedge core_clk) #1;
        pin_req = 1'h1;
        exp_q.push_back(e);
        nm_q.push_back(n);
        @(posedge core_clk) #1;
        pin_req = 1'h0;
    endtask : pins
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk) #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'h1;
        @(posedge core_clk) #1;
        reg_wr = 1'h0;
    endtask : wr
    task automatic set_tick(input logic [7:0] mn, input logic [7:0] hr, input logic [7:0] dy, input logic [7:0] wk);
        wr(8'h01, mn);
        wr(8'h02, hr);
        wr(8'h04, dy);
        wr(8'h03, wk);
        sec_carry = 1'h1;
        @(posedge core_clk) #1;
        sec_carry = 1'h0;
    endtask : set_tick
    initial begin
        repeat (6) @(posedge core_clk);
        #1 srst = 1'h0;
        for (int a = 0; a < 6; a++) rd(8'(a), (a == 3 || a == 4) ? 8'h01 : 8'h00, "reset");
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            wr(8'h01, d);
            rd(8'h01, d & 8'h7f, "minutes");
            wr(8'h02, d);
            rd(8'h02, d & 8'h7f, "hours");
            wr(8'h04, d);
            rd(8'h04, d & 8'h3f, "day");
            wr(8'h03, d);
            rd(8'h03, d & 8'h0f, "weekday");
            wr(8'h00, d);
            rd(8'h00, 8'h00, "unmapped");
        end
        for (int lp = 0; lp < 2; lp++) begin
            leap_year = lp[0];
            set_tick(8'h59, 8'h23, 8'h28, 8'h07);
            rd(8'h01, 8'h00, "min wrap");
            rd(8'h02, 8'h00, "hour wrap");
            rd(8'h04, lp ? 8'h29 : 8'h01, "feb end");
            rd(8'h03, 8'h01, "weekday_field wrap");
        end
        for (int k = 0; k < 3; k++) begin
            set_tick(8'h59, hin[k], 8'h10, 8'h02);
            rd(8'h02, hout[k], "hour 12h");
            rd(8'h04, k == 0 ? 8'h11 : 8'h10, "day 12h");
        end
        primary_power_lost = 1'h1;
        rd(8'h03, 8'h02, "pwr wait");
        // The pin needs four edges through the synchroniser before the flag shows
        repeat (2) @(posedge core_clk);
        rd(8'h03, 8'h12, "pwr set");
        pins(8'h02, "pwr pin");
        primary_power_lost = 1'h0;
        wr(8'h03, 8'h1b);
        rd(8'h03, 8'h0b, "pwr clr");
        pins(8'h01, "clr pin");
        osc_enable = 1'h1;
        // Reads land between the 31st and the 33rd counted rise
        repeat (250) @(posedge core_clk);
        rd(8'h03, 8'h0b, "osc early");
        repeat (8) @(posedge core_clk);
        rd(8'h03, 8'h2b, "osc run");
        pins(8'h05, "osc pin");
        osc_enable = 1'h0;
        repeat (4) @(posedge core_clk);
        rd(8'h03, 8'h0b, "osc stop");
        osc_enable = 1'h1;
        repeat (280) @(posedge core_clk);
        rd(8'h03, 8'h2b, "osc again");
        osc_stall = 1'h1;
        repeat (70) @(posedge core_clk);
        rd(8'h03, 8'h0b, "osc lost");
        pins(8'h01, "pins end");
        repeat (3) @(posedge core_clk);
        cmp_count++;
        if (carry_n != 1) begin
            err_count++;
            $display("BAD day_carry count exp 1 got %0d", carry_n);
        end
        cmp_count++;
        if (clr_n != 1) begin
            err_count++;
            $display("BAD timestamp_clear count exp 1 got %0d", clr_n);
        end
        print_verdict();
    end
endmodule : rtc_time_date_tb_top
`default_nettype wire

// ==== verilog/rtc_defs.svh ====
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// Register offsets
`define RTC_ADDR_SECONDS 8'h00
`define RTC_ADDR_MINUTES 8'h01
`define RTC_ADDR_HOURS 8'h02
`define RTC_ADDR_WEEKDAY 8'h03
`define RTC_ADDR_DAY 8'h04

// Weekday register bit positions
`define RTC_WK_OSC_BIT 5
`define RTC_WK_PWR_BIT 4
`define RTC_WK_VBAT_BIT 3

// Hours register bit positions
`define RTC_HR_FMT_BIT 6
`define RTC_HR_PM_BIT 5

// Reset values
`define RTC_RST_MINUTES 7'h00
`define RTC_RST_HOURS 7'h00
`define RTC_RST_WEEKDAY 3'h1
`define RTC_RST_DAY 6'h01

// BCD limits
`define RTC_BCD_NINE 4'h9
`define RTC_MIN_LAST 7'h59
`define RTC_H24_LAST 6'h23
`define RTC_H12_ELEVEN 5'h11
`define RTC_H12_TWELVE 5'h12
`define RTC_H12_ONE 5'h01
`define RTC_WK_FIRST 3'h1
`define RTC_WK_LAST 3'h7
`define RTC_DAY_FIRST 6'h01
`define RTC_DAY_28 6'h28
`define RTC_DAY_29 6'h29
`define RTC_DAY_30 6'h30
`define RTC_DAY_31 6'h31
`define RTC_MONTH_FEB 5'h02
`define RTC_MONTH_APR 5'h04
`define RTC_MONTH_JUN 5'h06
`define RTC_MONTH_SEP 5'h09
`define RTC_MONTH_NOV 5'h11

// Oscillator supervision
`define RTC_OSC_RUN_EDGES 6'h20
`define RTC_CLK_PERIOD_NS 20
`define RTC_OSC_LOSS_US 100

`endif

// ==== verilog/rtc_pkg.sv ====
package rtc_pkg;

    // Timekeeping fields, stored without their unimplemented bits
    typedef struct packed {
        logic [6:0] minutes;
        logic [6:0] hours;
        logic [2:0] weekday;
        logic [5:0] day;
    } rtc_time_type;

    typedef struct packed {
        logic osc_running;
        logic power_loss;
        logic backup_enable;
    } rtc_status_type;

endpackage : rtc_pkg

// ==== verilog/rtc_time_date.sv ====
// What this block does
// R1 - Minute tens digit in bits 6-4, offset 1
// R2 - Minute ones digit 0-9 in low nibble
// R3 - Hours bit 6 selects 12 or 24 hour
// R4 - Twelve-hour bit 5 is PM flag
// R5 - Twelve-hour tens bit 4, ones bits 3-0
// R6 - Twenty-four-hour tens 0-2 in bits 5-4
// R7 - Day tens 0-3 bits 5-4, offset 4
// R8 - Day ones 0-9 in low nibble
// R9 - Unimplemented bits read zero, ignore writes
// R10 - Oscillator flag sets after 32 cycles, clears stopped
// R11 - Weekday counts 1 to 7 at midnight
// R12 - February ends at 29 leap, else 28
// R13 - Twelve-hour wraps 11:59:59 PM to 12 AM, carries
// R14 - Power flag set by loss, weekday register write clears
// R15 - Weekday bit 3 enables backup supply
`include "rtc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rtc_time_date #(
    parameter int OSC_LOSS_CYCLES = (`RTC_OSC_LOSS_US * 1000) / `RTC_CLK_PERIOD_NS
) (
    input wire logic core_clk, // 50 MHz clock
    input wire logic srst, // Synchronous reset, high
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, one cycle after address
    input wire logic sec_carry, // Seconds rollover pulse
    input wire logic [4:0] month_bcd, // Current month, BCD
    input wire logic leap_year, // Current year is a leap year
    input wire logic osc_enable, // Oscillator start or external clock enable
    input wire logic osc_clk_in, // 32.768 kHz oscillator, asynchronous
    input wire logic primary_power_lost, // Primary supply lost, asynchronous level
    output logic day_carry, // Day rolled over into month, pulse
    output logic osc_running_flag, // Oscillator running status
    output logic power_loss_flag, // Primary power was lost
    output logic backup_supply_enable, // Backup supply input enabled
    output logic timestamp_clear // Clear logged time stamps, pulse
);

    localparam int LOSS_W = $clog2(OSC_LOSS_CYCLES + 1);
    localparam logic [LOSS_W-1:0] LOSS_LAST = LOSS_W'(OSC_LOSS_CYCLES - 1);

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == `RTC_BCD_NINE) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    function automatic logic [5:0] last_day(input logic [4:0] month, input logic leap);
        case (month)
            `RTC_MONTH_FEB: last_day = leap ? `RTC_DAY_29 : `RTC_DAY_28;
            `RTC_MONTH_APR, `RTC_MONTH_JUN, `RTC_MONTH_SEP, `RTC_MONTH_NOV: last_day = `RTC_DAY_30;
            default: last_day = `RTC_DAY_31;
        endcase
    endfunction : last_day

    rtc_pkg::rtc_time_type tm, next_tm;
    rtc_pkg::rtc_status_type st, next_st;
    logic [2:0] osc_sync, next_osc_sync;
    logic [2:0] pwr_sync, next_pwr_sync;
    logic osc_level, next_osc_level;
    logic pwr_level, next_pwr_level;
    logic [5:0] osc_edges, next_osc_edges;
    logic [LOSS_W-1:0] loss_cnt, next_loss_cnt;
    logic [7:0] next_rdata;
    logic next_day_carry;
    logic next_ts_clear;

    always_comb begin
        logic min_carry;
        logic hour_carry;
        logic osc_rise;
        logic pwr_rise;
        logic wr_wk;
        logic [7:0] tmp;
        min_carry = 1'b0;
        hour_carry = 1'b0;
        osc_rise = 1'b0;
        pwr_rise = 1'b0;
        wr_wk = 1'b0;
        tmp = 8'h00;
        next_tm = tm;
        next_st = st;
        next_day_carry = 1'b0;
        next_ts_clear = 1'b0;

        // Three-stage synchronisers; a change counts once stages two and three agree
        next_osc_sync = {osc_sync[1:0], osc_clk_in};
        next_pwr_sync = {pwr_sync[1:0], primary_power_lost};
        next_osc_level = (osc_sync[1] == osc_sync[2]) ? osc_sync[2] : osc_level;
        next_pwr_level = (pwr_sync[1] == pwr_sync[2]) ? pwr_sync[2] : pwr_level;
        osc_rise = next_osc_level & ~osc_level;
        pwr_rise = next_pwr_level & ~pwr_level;

        // Oscillator supervision
        next_osc_edges = osc_edges;
        next_loss_cnt = loss_cnt;
        if (!osc_enable) begin
            next_osc_edges = 6'h00;
            next_loss_cnt = '0;
            next_st.osc_running = 1'b0; // R10
        end else if (osc_rise) begin
            next_loss_cnt = '0;
            if (osc_edges != `RTC_OSC_RUN_EDGES) begin
                next_osc_edges = osc_edges + 6'h01;
            end
            if (osc_edges + 6'h01 >= `RTC_OSC_RUN_EDGES) begin
                next_st.osc_running = 1'b1; // R10
            end
        end else if (loss_cnt == LOSS_LAST) begin
            next_osc_edges = 6'h00;
            next_st.osc_running = 1'b0; // R10
        end else begin
            next_loss_cnt = loss_cnt + LOSS_W'(1);
        end

        // Minutes, hours, day and weekday counting
        if (sec_carry) begin
            if (tm.minutes == `RTC_MIN_LAST) begin
                next_tm.minutes = 7'h00;
                min_carry = 1'b1;
            end else begin
                tmp = bcd_inc({1'b0, tm.minutes}); // R1 R2
                next_tm.minutes = tmp[6:0];
            end
        end
        if (min_carry) begin
            if (tm.hours[`RTC_HR_FMT_BIT]) begin // R3
                if (tm.hours[4:0] == `RTC_H12_TWELVE) begin
                    next_tm.hours[4:0] = `RTC_H12_ONE; // R5
                end else if (tm.hours[4:0] == `RTC_H12_ELEVEN) begin
                    next_tm.hours[4:0] = `RTC_H12_TWELVE;
                    next_tm.hours[`RTC_HR_PM_BIT] = ~tm.hours[`RTC_HR_PM_BIT]; // R4
                    hour_carry = tm.hours[`RTC_HR_PM_BIT]; // R13
                end else begin
                    tmp = bcd_inc({3'h0, tm.hours[4:0]}); // R5
                    next_tm.hours[4:0] = tmp[4:0];
                end
            end else begin
                if (tm.hours[5:0] == `RTC_H24_LAST) begin
                    next_tm.hours[5:0] = 6'h00;
                    hour_carry = 1'b1;
                end else begin
                    tmp = bcd_inc({2'h0, tm.hours[5:0]}); // R6
                    next_tm.hours[5:0] = tmp[5:0];
                end
            end
        end
        if (hour_carry) begin
            next_tm.weekday = (tm.weekday == `RTC_WK_LAST) ? `RTC_WK_FIRST : tm.weekday + 3'h1; // R11
            if (tm.day == last_day(month_bcd, leap_year)) begin // R12
                next_tm.day = `RTC_DAY_FIRST;
                next_day_carry = 1'b1;
            end else begin
                tmp = bcd_inc({2'h0, tm.day}); // R7 R8
                next_tm.day = tmp[5:0];
            end
        end

        // Register writes take precedence over counting; upper bits are dropped
        wr_wk = reg_wr && (reg_addr == `RTC_ADDR_WEEKDAY);
        if (reg_wr) begin
            case (reg_addr)
                `RTC_ADDR_MINUTES: next_tm.minutes = reg_wdata[6:0]; // R1 R2 R9
                `RTC_ADDR_HOURS: next_tm.hours = reg_wdata[6:0]; // R3 R9
                `RTC_ADDR_WEEKDAY: begin
                    next_tm.weekday = reg_wdata[2:0]; // R9
                    next_st.backup_enable = reg_wdata[`RTC_WK_VBAT_BIT]; // R15
                end
                `RTC_ADDR_DAY: next_tm.day = reg_wdata[5:0]; // R7 R8 R9
                default: ;
            endcase
        end

        // Power-loss flag: a loss in the same cycle as a write keeps the flag set
        if (pwr_rise) begin
            next_st.power_loss = 1'b1; // R14
        end else if (wr_wk) begin
            next_st.power_loss = 1'b0; // R14
            next_ts_clear = st.power_loss; // R14
        end

        // Read data, unimplemented bits return zero
        case (reg_addr)
            `RTC_ADDR_MINUTES: next_rdata = {1'b0, tm.minutes}; // R9
            `RTC_ADDR_HOURS: next_rdata = {1'b0, tm.hours}; // R9
            `RTC_ADDR_WEEKDAY: next_rdata = {2'b00, st.osc_running, st.power_loss, st.backup_enable, tm.weekday};
            `RTC_ADDR_DAY: next_rdata = {2'b00, tm.day}; // R9
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tm <= '{minutes: `RTC_RST_MINUTES, hours: `RTC_RST_HOURS, weekday: `RTC_RST_WEEKDAY, day: `RTC_RST_DAY};
            st <= '0;
            osc_sync <= 3'h0;
            pwr_sync <= 3'h0;
            osc_level <= 1'b0;
            pwr_level <= 1'b0;
            osc_edges <= 6'h00;
            loss_cnt <= '0;
            reg_rdata <= 8'h00;
            day_carry <= 1'b0;
            timestamp_clear <= 1'b0;
            osc_running_flag <= 1'b0;
            power_loss_flag <= 1'b0;
            backup_supply_enable <= 1'b0;
        end else begin
            tm <= next_tm;
            st <= next_st;
            osc_sync <= next_osc_sync;
            pwr_sync <= next_pwr_sync;
            osc_level <= next_osc_level;
            pwr_level <= next_pwr_level;
            osc_edges <= next_osc_edges;
            loss_cnt <= next_loss_cnt;
            reg_rdata <= next_rdata;
            day_carry <= next_day_carry;
            timestamp_clear <= next_ts_clear;
            osc_running_flag <= next_st.osc_running;
            power_loss_flag <= next_st.power_loss;
            backup_supply_enable <= next_st.backup_enable;
        end
    end

endmodule : rtc_time_date

`default_nettype wire
